// ==== hw/dbu_unit.sv ====
// debug breakpoint unit: address match, status, control, exceptions
//
// Operation
// RULE1: four address slots compared each cycle
// RULE2: extensions off, reserved slots alias control/status
// RULE3: extensions on, reserved slot access is undefined
// RULE4: enabled breakpoint match sets its hit flag
// RULE5: disabled matches flag too, raise nothing; they still set irq_stat_reg bit 3 and can raise irq
// RULE6: guarded debug access flags and faults first
// RULE7: trap flag gives step trap and flag
// RULE8: task trap bit gives task flag, exception
// RULE9: local enables cleared on task switch
// RULE10: global enables survive switches, override local
// RULE11: exact-match bits stored, otherwise ignored
// RULE12: guard bit enables access fault, cleared on exception
// RULE13: two-bit type and length per breakpoint
// RULE14: software avoids length 10b, exec length 00b
// RULE15: software uses i/o type only with extensions
// RULE16: data, io, step, task are vector 01h traps
// RULE17: exec match and access detect are 01h faults
// RULE18: opcode cch gives vector 03h trap
// RULE19: all flags of one instruction set together
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module dbu_unit (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // software register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // core state
  input  wire logic [31:0]       control_register_four,
  input  wire logic              flags_trap,
  // processor cycle to match
  input  wire dbu_pkg::dbu_cycle_t cyc,
  // instruction events
  input  wire logic              insn_retire,
  input  wire logic              insn_dbg_move,
  input  wire logic [2:0]        insn_dbg_slot,
  input  wire logic [7:0]        insn_opcode,
  input  wire logic              task_switch,
  input  wire logic              task_trap_bit,
  // results
  output dbu_pkg::dbu_exc_t      exc,
  output logic                   irq
);
  // ==========================================================
  // state
  logic [31:0] bp_addr_reg [4];   // breakpoint_address_regs
  logic [31:0] status_reg;        // debug_status_reg
  logic [31:0] control_reg;       // debug_control_reg
  logic [3:0]  irq_stat_reg;      // access, step, task, break
  logic [3:0]  irq_mask_reg;
  logic [31:0] rdata_reg;
  dbu_pkg::dbu_exc_t exc_reg;

  // extensions enable pulled out of the core register
  wire ext_en = control_register_four[dbu_pkg::EXT_EN_POS];

  // ==========================================================
  // breakpoint matching
  // byte mask of length field; 10b treated as four, software avoids it
  function automatic logic [31:0] len_mask(input logic [1:0] len);
    unique case (len)
      dbu_pkg::LEN_ONE: len_mask = 32'hffffffff;
      dbu_pkg::LEN_TWO: len_mask = 32'hfffffffe;
      default:          len_mask = 32'hfffffffc; // RULE14
    endcase
  endfunction

  // per-slot results, bit g belongs to breakpoint g
  logic [3:0] hit;          // raw match per slot
  logic [3:0] bp_en;        // local or global enable
  logic [3:0] hit_fault;    // exec matches, enabled
  logic [3:0] hit_trap;     // data/io matches, enabled
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bp
      // type and length fields of this slot
      wire [1:0] typ = control_reg[dbu_pkg::CT_TYPE_BASE
                                   + g*dbu_pkg::CT_FIELD_STRIDE +: 2];
      wire [1:0] len = control_reg[dbu_pkg::CT_LEN_BASE
                                   + g*dbu_pkg::CT_FIELD_STRIDE +: 2];
      wire [31:0] msk = len_mask(len);
      // start-address check against the aligned window of the breakpoint length
      wire addr_eq = ((cyc.addr & msk) == (bp_addr_reg[g] & msk)); // RULE1
      // cycle kind chosen by the type field
      wire kind_ok =
        (typ == dbu_pkg::TY_EXEC  && cyc.is_fetch) ||
        (typ == dbu_pkg::TY_WRITE && cyc.is_write && !cyc.is_io
                                  && !cyc.is_fetch) ||
        (typ == dbu_pkg::TY_IO    && cyc.is_io && ext_en) || // RULE15
        (typ == dbu_pkg::TY_RDWR  && !cyc.is_io && !cyc.is_fetch); // RULE13
      assign hit[g] = cyc.valid && addr_eq && kind_ok;
      // global enable overrides a clear local enable
      assign bp_en[g] = control_reg[2*g] | control_reg[2*g+1]; // RULE10
      assign hit_fault[g] = hit[g] && bp_en[g]
                            && typ == dbu_pkg::TY_EXEC; // RULE17
      assign hit_trap[g] = hit[g] && bp_en[g]
                           && typ != dbu_pkg::TY_EXEC; // RULE16 RULE5
    end
  endgenerate

  // ==========================================================
  // instruction-level events
  // undefined opcode wins, so a reserved move reports one cause only
  wire res_slot = insn_dbg_move &&
                  (insn_dbg_slot == dbu_pkg::SLOT_RES_LOW ||
                   insn_dbg_slot == dbu_pkg::SLOT_RES_HIGH);
  wire undef_ev = res_slot && ext_en;                         // RULE3
  // guard check comes before the move may happen
  wire access_ev = insn_dbg_move && !undef_ev
                   && control_reg[dbu_pkg::CT_GUARD_POS];     // RULE6
  wire step_ev   = insn_retire && flags_trap;                 // RULE7
  wire task_ev   = task_switch && task_trap_bit;              // RULE8
  wire brk_ev    = insn_retire && insn_opcode == dbu_pkg::OPC_BREAK;
  // faults stop the instruction, traps follow it; one report per cycle
  wire fault_any = access_ev || (|hit_fault);
  wire trap_any  = step_ev || task_ev || (|hit_trap);
  wire dbg_exc   = fault_any || trap_any;

  // ==========================================================
  // software port decode; reserved slots alias when extensions off
  function automatic logic [2:0] map_slot(input logic [2:0] s);
    unique case (s)
      dbu_pkg::SLOT_RES_LOW:  map_slot = dbu_pkg::SLOT_STATUS;
      dbu_pkg::SLOT_RES_HIGH: map_slot = dbu_pkg::SLOT_CONTROL;
      default:                map_slot = s;
    endcase
  endfunction
  // offsets 0..7 are debug slots, 8 and 9 the interrupt pair
  wire       is_slot  = (reg_addr[3] == 1'b0);
  wire [2:0] eff_slot = map_slot(reg_addr[2:0]);              // RULE2
  // reserved slots are dead while extensions are on
  wire slot_live = is_slot && !(ext_en && reg_addr[2:1] == 2'b10);
  // write strobes, one per storage element
  wire wr_ctl  = reg_wr && slot_live && eff_slot == dbu_pkg::SLOT_CONTROL;
  wire wr_sta  = reg_wr && slot_live && eff_slot == dbu_pkg::SLOT_STATUS;
  wire wr_bp   = reg_wr && slot_live && eff_slot[2] == 1'b0;
  wire wr_istat = reg_wr && reg_addr == dbu_pkg::OFS_IRQ_STATUS;
  wire wr_imask = reg_wr && reg_addr == dbu_pkg::OFS_IRQ_MASK;

  logic [31:0] rd_mux;
  // read selection; anything unmapped reads as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (slot_live) begin
      unique case (eff_slot)
        dbu_pkg::SLOT_STATUS:  rd_mux = status_reg;
        dbu_pkg::SLOT_CONTROL: rd_mux = control_reg;
        default: rd_mux = eff_slot[2] ? 32'h00000000
                                      : bp_addr_reg[eff_slot[1:0]];
      endcase
    end else if (reg_addr == dbu_pkg::OFS_IRQ_STATUS) begin
      rd_mux = {28'h0000000, irq_stat_reg};
    end else if (reg_addr == dbu_pkg::OFS_IRQ_MASK) begin
      rd_mux = {28'h0000000, irq_mask_reg};
    end
  end

  // ==========================================================
  // next values of status and control
  logic [31:0] status_next;
  logic [31:0] control_next;
  // status: software write first, hardware sets on top
  always_comb begin
    status_next = status_reg;
    if (wr_sta) status_next = reg_wdata | dbu_pkg::STATUS_RO1;
    // hardware sets win over a software write in the same cycle
    status_next[3:0] = status_next[3:0] | hit;              // RULE4 RULE5
    if (access_ev) status_next[dbu_pkg::ST_ACCESS_POS] = 1'b1; // RULE6
    if (step_ev)   status_next[dbu_pkg::ST_STEP_POS]   = 1'b1; // RULE7
    if (task_ev)   status_next[dbu_pkg::ST_TASK_POS]   = 1'b1; // RULE8 RULE19
  end
  // control: write first, then task-switch and exception clears
  always_comb begin
    control_next = control_reg;
    // exact bits are kept as written and read nowhere else
    if (wr_ctl) control_next = reg_wdata | dbu_pkg::CONTROL_RO1; // RULE11
    // a hardware clear beats a software write in the same cycle
    if (task_switch) begin
      for (int i = 0; i < 4; i++) control_next[2*i] = 1'b0;   // RULE9
    end
    if (dbg_exc) control_next[dbu_pkg::CT_GUARD_POS] = 1'b0;  // RULE12
  end

  // exception selection: faults before traps, int3 last
  // limitation: one vector per cycle; lower debug causes only leave flags, a lost int3 leaves nothing
  dbu_pkg::dbu_exc_t exc_next;
  always_comb begin
    exc_next = '0;
    if (undef_ev) begin
      exc_next = '{valid: 1'b1, fault: 1'b1, vector: dbu_pkg::VEC_UNDEF};
    end else if (fault_any) begin
      exc_next = '{valid: 1'b1, fault: 1'b1, vector: dbu_pkg::VEC_DEBUG};
    end else if (trap_any) begin
      exc_next = '{valid: 1'b1, fault: 1'b0, vector: dbu_pkg::VEC_DEBUG};
    end else if (brk_ev) begin
      exc_next = '{valid: 1'b1, fault: 1'b0,
                   vector: dbu_pkg::VEC_BREAK};               // RULE18
    end
  end

  // interrupt events: access, step, task, any breakpoint hit
  wire [3:0] irq_ev = {|hit, task_ev, step_ev, access_ev};
  // set wins over a write-one clear in the same cycle
  wire [3:0] irq_stat_next =
    (irq_stat_reg & ~(wr_istat ? reg_wdata[3:0] : 4'h0)) | irq_ev;

  // ==========================================================
  // registers
  // breakpoint address slots, plain storage
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) bp_addr_reg[i] <= dbu_pkg::ADDR_RST;
    end else if (wr_bp) begin
      bp_addr_reg[eff_slot[1:0]] <= reg_wdata;               // RULE1
    end
  end

  // status, control, interrupt, read-back and exception state
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status_reg   <= dbu_pkg::STATUS_RST;
      control_reg  <= dbu_pkg::CONTROL_RST;
      irq_stat_reg <= dbu_pkg::IRQ_RST;
      irq_mask_reg <= dbu_pkg::IRQ_RST;
      rdata_reg    <= 32'h00000000;
      exc_reg      <= '0;
    end else begin
      status_reg   <= status_next;
      control_reg  <= control_next;
      irq_stat_reg <= irq_stat_next;
      if (wr_imask) irq_mask_reg <= reg_wdata[3:0];
      rdata_reg    <= reg_rd ? rd_mux : 32'h00000000;
      exc_reg      <= exc_next;
    end
  end

  // rdata and exc straight from flip-flops, irq gated from the irq status and mask flip-flops
  assign reg_rdata = rdata_reg;
  assign exc       = exc_reg;
  assign irq       = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // assertions
  a_hit_flag_set: assert property ( // RULE4
    @(posedge sys_clk) disable iff (!rst_b)
    hit[0] |=> status_reg[0])
    else $error("hit flag 0 not set");

  a_dis_no_exc: assert property ( // RULE5
    @(posedge sys_clk) disable iff (!rst_b)
    (|hit) && !(|(hit & bp_en)) && !access_ev && !step_ev && !task_ev
    && !undef_ev && !brk_ev |=> !exc.valid)
    else $error("exception for disabled breakpoint");

  a_undef_slot: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!rst_b)
    undef_ev |=> exc.valid && exc.vector == dbu_pkg::VEC_UNDEF)
    else $error("reserved slot access not undefined");

  a_access_fault: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!rst_b)
    access_ev |=> status_reg[dbu_pkg::ST_ACCESS_POS] && exc.fault
    && exc.vector == dbu_pkg::VEC_DEBUG)
    else $error("guarded access not faulted");

  a_step_trap: assert property ( // RULE7
    @(posedge sys_clk) disable iff (!rst_b)
    step_ev && !fault_any && !undef_ev |=> exc.valid && !exc.fault
    && status_reg[dbu_pkg::ST_STEP_POS])
    else $error("single step trap missing");

  a_task_flag: assert property ( // RULE8
    @(posedge sys_clk) disable iff (!rst_b)
    task_ev |=> status_reg[dbu_pkg::ST_TASK_POS] && exc.valid)
    else $error("task switch flag missing");

  a_local_clear: assert property ( // RULE9
    @(posedge sys_clk) disable iff (!rst_b)
    task_switch |=> !control_reg[0] && !control_reg[2] && !control_reg[4]
    && !control_reg[6])
    else $error("local enables survived task switch");

  a_global_keep: assert property ( // RULE10
    @(posedge sys_clk) disable iff (!rst_b)
    task_switch && !wr_ctl |=> $stable(control_reg[1]))
    else $error("global enable changed on task switch");

  a_guard_clear: assert property ( // RULE12
    @(posedge sys_clk) disable iff (!rst_b)
    dbg_exc |=> !control_reg[dbu_pkg::CT_GUARD_POS])
    else $error("guard bit not cleared");

  a_brk_vector: assert property ( // RULE18
    @(posedge sys_clk) disable iff (!rst_b)
    brk_ev && !dbg_exc && !undef_ev |=> exc.vector == dbu_pkg::VEC_BREAK
    && !exc.fault)
    else $error("int3 vector wrong");

  a_rd_latency: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside read slot");

  a_bp_write: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!rst_b)
    reg_wr && reg_addr == {1'b0, dbu_pkg::SLOT_BP0}
    |=> bp_addr_reg[0] == $past(reg_wdata))
    else $error("breakpoint address write lost");

  a_alias_status: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd && !ext_en && reg_addr == {1'b0, dbu_pkg::SLOT_RES_LOW}
    |=> reg_rdata == $past(status_reg))
    else $error("low reserved slot does not alias status");

  a_alias_control: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd && !ext_en && reg_addr == {1'b0, dbu_pkg::SLOT_RES_HIGH}
    |=> reg_rdata == $past(control_reg))
    else $error("high reserved slot does not alias control");

  a_res_refused: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd && ext_en && reg_addr[3:1] == 3'b010
    |=> reg_rdata == 32'h00000000)
    else $error("reserved slot readable with extensions on");

  a_exec_fault: assert property ( // RULE17
    @(posedge sys_clk) disable iff (!rst_b)
    (|hit_fault) && !undef_ev |=> exc.valid && exc.fault
    && exc.vector == dbu_pkg::VEC_DEBUG)
    else $error("execution breakpoint not faulted");

  a_data_trap: assert property ( // RULE16
    @(posedge sys_clk) disable iff (!rst_b)
    (|hit_trap) && !fault_any && !undef_ev |=> exc.valid && !exc.fault
    && exc.vector == dbu_pkg::VEC_DEBUG)
    else $error("data breakpoint not trapped");

  a_exact_kept: assert property ( // RULE11
    @(posedge sys_clk) disable iff (!rst_b)
    wr_ctl |=> control_reg[dbu_pkg::CT_LEXACT_POS]
               == $past(reg_wdata[dbu_pkg::CT_LEXACT_POS])
    && control_reg[dbu_pkg::CT_GEXACT_POS]
               == $past(reg_wdata[dbu_pkg::CT_GEXACT_POS]))
    else $error("exact-match bits not stored");

  a_all_flags: assert property ( // RULE19
    @(posedge sys_clk) disable iff (!rst_b)
    step_ev && hit[0] |=> status_reg[dbu_pkg::ST_STEP_POS] && status_reg[0])
    else $error("flags of one instruction not set together");

  a_irq_set: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (|hit) |=> irq_stat_reg[3])
    else $error("hit event not latched for interrupt");

  // cover points for the main scenarios
  c_exec_fault: cover property (@(posedge sys_clk) disable iff (!rst_b)
    |hit_fault);
  c_data_trap:  cover property (@(posedge sys_clk) disable iff (!rst_b)
    |hit_trap);
  c_step_hit:   cover property (@(posedge sys_clk) disable iff (!rst_b)
    step_ev && (|hit_trap));
  c_io_trap:    cover property (@(posedge sys_clk) disable iff (!rst_b)
    (|hit_trap) && ext_en && cyc.is_io);
  c_irq:        cover property (@(posedge sys_clk) disable iff (!rst_b)
    irq);
endmodule
`default_nettype wire

// ==== hw/dbu_pkg.sv ====
// shared constants and carrier types for the debug breakpoint unit
package dbu_pkg;
  // ==========================================================
  // register slot numbers on the debug move port
  localparam logic [2:0] SLOT_BP0        = 3'h0;
  localparam logic [2:0] SLOT_RES_LOW    = 3'h4;
  localparam logic [2:0] SLOT_RES_HIGH   = 3'h5;
  localparam logic [2:0] SLOT_STATUS     = 3'h6;
  localparam logic [2:0] SLOT_CONTROL    = 3'h7;
  // ==========================================================
  // local register offsets on the software port
  localparam logic [3:0] OFS_SLOT_BASE   = 4'h0;  // 0..7 debug slots
  localparam logic [3:0] OFS_IRQ_STATUS  = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK    = 4'h9;
  // ==========================================================
  // status field positions
  localparam int ST_ACCESS_POS   = 13;
  localparam int ST_STEP_POS     = 14;
  localparam int ST_TASK_POS     = 15;
  // control field positions
  localparam int CT_LEXACT_POS   = 8;
  localparam int CT_GEXACT_POS   = 9;
  localparam int CT_GUARD_POS    = 13;
  localparam int CT_TYPE_BASE    = 16;
  localparam int CT_LEN_BASE     = 18;
  localparam int CT_FIELD_STRIDE = 4;
  // ==========================================================
  // reset values
  localparam logic [31:0] STATUS_RST  = 32'hffff0ff0;
  localparam logic [31:0] CONTROL_RST = 32'h00000400;
  localparam logic [31:0] STATUS_RO1  = 32'hffff0ff0; // reads as one
  localparam logic [31:0] CONTROL_RO1 = 32'h00000400;
  localparam logic [31:0] ADDR_RST    = 32'h00000000;
  localparam logic [3:0]  IRQ_RST     = 4'h0;
  // ==========================================================
  // vectors and opcode
  localparam logic [7:0] VEC_DEBUG    = 8'h01;
  localparam logic [7:0] VEC_BREAK    = 8'h03;
  localparam logic [7:0] VEC_UNDEF    = 8'h06;
  localparam logic [7:0] OPC_BREAK    = 8'hcc;
  localparam logic [2:0] EXT_EN_POS   = 3'h3;
  // ==========================================================
  // breakpoint type and length encodings
  typedef enum logic [1:0] {
    TY_EXEC  = 2'b00,
    TY_WRITE = 2'b01,
    TY_IO    = 2'b10,
    TY_RDWR  = 2'b11
  } dbu_type_t;
  localparam logic [1:0] LEN_ONE  = 2'b00;
  localparam logic [1:0] LEN_TWO  = 2'b01;
  localparam logic [1:0] LEN_FOUR = 2'b11;
  // ==========================================================
  // processor cycle presented for matching
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        is_fetch;
    logic        is_write;
    logic        is_io;
    logic [1:0]  size;    // 0 one, 1 two, 3 four bytes
  } dbu_cycle_t;
  // exception report to the core
  typedef struct packed {
    logic       valid;
    logic       fault;    // 1 fault, 0 trap
    logic [7:0] vector;
  } dbu_exc_t;
endpackage

// ==== testbench/test_dbu_unit.sv ====
// self-checking bench for the debug breakpoint unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_dbu_unit;
  // ==========================================================
  // stimulus and observed signals
  logic                 sys_clk;
  logic                 rst_b;
  logic [3:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  logic [31:0]          cr4;          // control_register_four copy
  logic                 flags_trap;
  dbu_pkg::dbu_cycle_t  cyc;
  logic                 insn_retire;
  logic                 insn_dbg_move;
  logic [2:0]           insn_dbg_slot;
  logic [7:0]           insn_opcode;
  logic                 task_switch;
  logic                 task_trap_bit;
  dbu_pkg::dbu_exc_t    exc;
  logic                 irq;
  int                   num_errors;   // mismatches seen
  int                   tests_run;    // comparisons made
  dbu_unit dut_u (
    .sys_clk               (sys_clk),
    .rst_b                 (rst_b),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .control_register_four (cr4),
    .flags_trap            (flags_trap),
    .cyc                   (cyc),
    .insn_retire           (insn_retire),
    .insn_dbg_move         (insn_dbg_move),
    .insn_dbg_slot         (insn_dbg_slot),
    .insn_opcode           (insn_opcode),
    .task_switch           (task_switch),
    .task_trap_bit         (task_trap_bit),
    .exc                   (exc),
    .irq                   (irq)
  );
  // ==========================================================
  // clock: 10 ns period
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // closing task, single exit of the run
  task give_verdict();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog: tests need well under 1000 cycles
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  // ==========================================================
  // register port: one-cycle strobes, data the cycle after read
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // drop every event pulse, then look at the registered report
  task fin(input logic [9:0] e);
    @(posedge sys_clk);
    cyc           <= '0;
    insn_retire   <= 1'b0;
    insn_dbg_move <= 1'b0;
    task_switch   <= 1'b0;
    #1 `CHK(exc, e)
  endtask
  // one processor cycle, kind k = {fetch, write, io}, one byte
  task cgo(input logic [31:0] a, input logic [2:0] k, input logic [9:0] e);
    @(posedge sys_clk);
    cyc <= {1'b1, a, k, 2'b00};
    fin(e);
  endtask
  task retire(input logic [7:0] op, input logic [9:0] e);
    @(posedge sys_clk);
    insn_opcode <= op;
    insn_retire <= 1'b1;
    fin(e);
  endtask
  task dmove(input logic [2:0] s, input logic [9:0] e);
    @(posedge sys_clk);
    insn_dbg_slot <= s;
    insn_dbg_move <= 1'b1;
    fin(e);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    num_errors = 0;
    tests_run = 0;
    rst_b = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, cr4, flags_trap} = '0;
    {cyc, insn_retire, insn_dbg_move, insn_dbg_slot} = '0;
    {insn_opcode, task_switch, task_trap_bit} = '0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    // reset values, unmapped offset reads zero
    rd(4'h6, 32'hffff0ff0);
    rd(4'h7, 32'h00000400);
    rd(4'h0, 32'h00000000);
    rd(4'h8, 32'h00000000);
    rd(4'ha, 32'h00000000);
    // extensions off: reserved slots alias status and control
    rd(4'h4, 32'hffff0ff0);
    rd(4'h5, 32'h00000400);
    // two breakpoints on one address, only the first enabled
    wr(4'h0, 32'h00001000);
    wr(4'h1, 32'h00001000);
    wr(4'h7, 32'h00110002);
    cgo(32'h00001000, 3'b010, 10'h201);
    rd(4'h6, 32'hffff0ff3);
    rd(4'h8, 32'h00000008);
    wr(4'h9, 32'h00000008);
    #1 `CHK(irq, 1'b1)
    wr(4'h8, 32'h00000008);
    #1 `CHK(irq, 1'b0)
    wr(4'h6, 32'h00000000);
    // no enables: flags only, no exception; a read does not hit a write breakpoint
    wr(4'h7, 32'h00110000);
    cgo(32'h00001000, 3'b010, 10'h000);
    rd(4'h6, 32'hffff0ff3);
    wr(4'h6, 32'h00000000);
    cgo(32'h00001000, 3'b000, 10'h000);
    rd(4'h6, 32'hffff0ff0);
    // four-byte read-or-write window, then one byte
    wr(4'h2, 32'h00002000);
    wr(4'h7, 32'h0f000020);
    cgo(32'h00002003, 3'b000, 10'h201);
    rd(4'h6, 32'hffff0ff4);
    wr(4'h6, 32'h00000000);
    wr(4'h7, 32'h03000020);
    cgo(32'h00002001, 3'b000, 10'h000);
    // execution breakpoint with length one byte is a fault
    wr(4'h3, 32'h00003000);
    wr(4'h7, 32'h00000080);
    cgo(32'h00003000, 3'b100, 10'h301);
    rd(4'h6, 32'hffff0ff8);
    wr(4'h6, 32'h00000000);
    // extensions on: reserved slots refuse
    cr4 <= 32'h00000008;
    rd(4'h4, 32'h00000000);
    dmove(3'h5, 10'h306);
    // i/o breakpoint only while extensions are on
    wr(4'h3, 32'h00000060);
    wr(4'h7, 32'h20000080);
    cgo(32'h00000060, 3'b001, 10'h201);
    rd(4'h6, 32'hffff0ff8);
    wr(4'h6, 32'h00000000);
    cr4 <= 32'h00000000;
    // guarded access faults first and drops the guard
    wr(4'h7, 32'h00002000);
    dmove(3'h0, 10'h301);
    rd(4'h6, 32'hffff2ff0);
    rd(4'h7, 32'h00000400);
    wr(4'h6, 32'h00000000);
    // exact-match bits are only stored
    wr(4'h7, 32'h00000300);
    rd(4'h7, 32'h00000700);
    // single step, together with an enabled data hit
    wr(4'h7, 32'h00010002);
    flags_trap <= 1'b1;
    @(posedge sys_clk);
    cyc <= {1'b1, 32'h00001000, 3'b010, 2'b00};
    insn_retire <= 1'b1;
    fin(10'h201);
    rd(4'h6, 32'hffff4ff1);
    flags_trap <= 1'b0;
    wr(4'h6, 32'h00000000);
    // software breakpoint opcode
    retire(8'hcc, 10'h203);
    // task switch: locals cleared, globals kept, task flag
    wr(4'h7, 32'h00000009);
    @(posedge sys_clk);
    task_trap_bit <= 1'b1;
    task_switch <= 1'b1;
    fin(10'h201);
    rd(4'h6, 32'hffff8ff0);
    rd(4'h7, 32'h00000408);
    give_verdict();
  end
endmodule
`default_nettype wire
